/* include/assp_pkg.sv */
// shared constants, types and decode helpers of the angle sensor serial port
package assp_pkg;

  // word framing
  localparam int unsigned WORD_BITS        = 16;
  localparam logic [3:0]  LAST_BIT         = 4'hf;
  localparam logic [3:0]  CRC_SWAP_BIT     = 4'h8;

  // command word field positions
  localparam int unsigned CMD_RW_POS       = 15;
  localparam int unsigned CMD_KEY_MSB      = 14;
  localparam int unsigned CMD_KEY_LSB      = 11;
  localparam int unsigned CMD_SNAP_POS     = 10;
  localparam int unsigned CMD_ADDR_MSB     = 9;
  localparam int unsigned CMD_ADDR_LSB     = 4;
  localparam int unsigned CMD_COUNT_MSB    = 3;
  localparam int unsigned CMD_COUNT_LSB    = 0;

  // access keys and the address window each key opens
  localparam logic [3:0]  KEY_NORMAL       = 4'h0;
  localparam logic [3:0]  KEY_CONFIG       = 4'ha;
  localparam logic [5:0]  NORMAL_ADDR_LAST = 6'h04;
  localparam logic [5:0]  CONFIG_ADDR_FST  = 6'h05;
  localparam logic [5:0]  CONFIG_ADDR_LAST = 6'h11;
  localparam logic [5:0]  STATUS_ADDR      = 6'h00;

  // crc generator
  localparam logic [7:0]  CRC_POLY         = 8'h1d;
  localparam logic [7:0]  CRC_SEED         = 8'hff;

  // idle levels of the synchronised pins: {data, chip select, sck}
  localparam logic [2:0]  PIN_IDLE         = 3'h6;

  // least deselect time the master keeps between transfers
  localparam int unsigned CLK_PERIOD_NS       = 25;
  localparam int unsigned DESELECT_MIN_NS     = 600;
  localparam int unsigned DESELECT_MIN_CYCLES =
    (DESELECT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // transfer sequencer, gray along idle-cmd-read-write-safety-done
  typedef enum logic [2:0] {
    ASSP_IDLE  = 3'h0,
    ASSP_CMD   = 3'h1,
    ASSP_RDATA = 3'h3,
    ASSP_WDATA = 3'h2,
    ASSP_SAFE  = 3'h6,
    ASSP_DONE  = 3'h7
  } assp_state_t;

  // key and address pair allowed or not
  function automatic logic assp_access_ok(input logic [3:0] key, input logic [5:0] addr);
    logic ok;
    ok = 1'b0;
    case (key)
      KEY_NORMAL: ok = (addr <= NORMAL_ADDR_LAST);
      KEY_CONFIG: ok = (addr >= CONFIG_ADDR_FST) && (addr <= CONFIG_ADDR_LAST);
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

/* rtl/assp_crc8.sv */
// bit-serial crc-8 generator, msb first
`timescale 1ns/1ps
module assp_crc8
  import assp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       restart,
  input  wire logic       step,
  input  wire logic       bit_in,
  output logic [7:0]      crc
);

  logic [7:0] next_crc;
  logic       feedback;

  // one polynomial step per bit, same result as the bytewise circuit
  always_comb begin
    feedback = crc[7] ^ bit_in;
    next_crc = crc;
    if (restart) begin
      next_crc = CRC_SEED;
    end else if (step) begin
      next_crc = {crc[6:0], 1'b0} ^ (feedback ? CRC_POLY : 8'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      crc <= CRC_SEED;
    end else if (ce) begin
      crc <= next_crc;
    end
  end

endmodule

/* rtl/assp_fifo.sv */
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module assp_fifo
  import assp_pkg::*;
#(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_fill;
  logic             do_push;
  logic             do_pop;

  // honest full and empty straight from the fill count
  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  // pointer and fill bookkeeping
  always_comb begin
    do_push     = in_valid && in_ready;
    do_pop      = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill   = fill;
    if (do_push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_fill = fill + 1'b1;
    end else if (do_pop && !do_push) begin
      next_fill = fill - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill   <= next_fill;
    end
  end

  // storage carries no reset, only valid entries are ever read
  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

/* rtl/assp_port.sv */
// serial slave port of the angle sensor: command decode, data words, safety word
`timescale 1ns/1ps
// Summary of operation
// - one shared data pin plus clock and select; push-pull or open-drain by config bit
// - traffic moves as whole command, data and safety words
// - command: direction, access key, snapshot select, address, word count
// - key 0000 opens addresses 0x00 to 0x04
// - key 1010 opens addresses 0x05 to 0x11
// - snapshot select picks buffered values, otherwise live values
// - select pulse without clock edges captures all snapshot buffers at once
// - safety bit 15 low after reset or watchdog overflow until read out
// - safety bit 14 low when any system error is flagged
// - safety bit 13 low after bad address or wrong key
// - safety bit 12 high only when both angle invalid flags are clear
// - safety bits 11 to 8 low on this sensor's bit, high elsewhere
// - safety bits 7 to 0 carry the transfer checksum
// - status bits 15 to 13 stay low until status address 00 is read
// - msb first, driven on rising clock, sampled on falling clock
// - read count zero sends one word and no safety word
// - crc-8 poly 0x1d over all bytes, seed all ones, sent inverted
module assp_port
  import assp_pkg::*;
#(
  parameter logic [1:0]  SENSOR_NUMBER = 2'h0,
  parameter int unsigned FIFO_DEPTH    = 8
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        sck,
  input  wire logic        chip_select_n,
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe_n,
  input  wire logic        data_pin_open_drain_select,
  output logic [5:0]       rd_addr,
  output logic             snapshot_select,
  input  wire logic [15:0] rd_live_data,
  input  wire logic [15:0] rd_snap_data,
  output logic             snapshot_capture,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [5:0]       wr_addr,
  output logic [15:0]      wr_data,
  input  wire logic        supply_error_flag,
  input  wire logic        system_fault_flag,
  input  wire logic        watchdog_overflow,
  input  wire logic        angle_invalid_flag,
  input  wire logic        raw_component_invalid_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_f;
  logic [2:0] pin_fd;
  logic [2:0] next_pin_f;

  // a level counts once stages two and three agree, filters single glitches
  always_comb begin
    next_pin_f = pin_f;
    for (int i = 0; i < 3; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_f[i] = pin_s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_f  <= PIN_IDLE;
      pin_fd <= PIN_IDLE;
    end else if (ce) begin
      pin_s1 <= {data_pin_in, chip_select_n, sck};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= next_pin_f;
      pin_fd <= pin_f;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic cs_high;
  logic din;

  // edges of the filtered levels
  assign sck_rise = pin_f[0] && !pin_fd[0];
  assign sck_fall = !pin_f[0] && pin_fd[0];
  assign cs_rise  = pin_f[1] && !pin_fd[1];
  assign cs_fall  = !pin_f[1] && pin_fd[1];
  assign cs_high  = pin_f[1];
  assign din      = pin_f[2];

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  assp_state_t state;
  assp_state_t next_state;
  logic [3:0]  bitcnt;
  logic [3:0]  next_bitcnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic        dout;
  logic        next_dout;
  logic        tx_on;
  logic        next_tx_on;
  logic [3:0]  key;
  logic [3:0]  next_key;
  logic        snap;
  logic        next_snap;
  logic [5:0]  addr;
  logic [5:0]  next_addr;
  logic [4:0]  words_left;
  logic [4:0]  next_words_left;
  logic        with_safety;
  logic        next_with_safety;
  logic        sck_seen;
  logic        next_sck_seen;
  logic        snap_pulse;
  logic        next_snap_pulse;
  logic        clr_pend;
  logic        next_clr_pend;
  logic        rst_ok;
  logic        next_rst_ok;
  logic        sys_ok;
  logic        next_sys_ok;
  logic        acc_ok;
  logic        next_acc_ok;

  logic [7:0]  crc;
  logic        crc_restart;
  logic        crc_step;
  logic        crc_bit;
  logic        push;
  logic        fifo_in_ready;
  logic [15:0] word_in;
  logic [15:0] tx_word;
  logic        sys_err;
  logic        acc_err;
  logic        clr_now;
  logic [3:0]  sensor_number_response;

  assign sensor_number_response    = ~(4'h1 << SENSOR_NUMBER);
  assign sys_err = supply_error_flag || system_fault_flag;
  assign word_in = {shift[14:0], din};

  always_comb begin
    next_state       = state;
    next_bitcnt      = bitcnt;
    next_shift       = shift;
    next_dout        = dout;
    next_tx_on       = tx_on;
    next_key         = key;
    next_snap        = snap;
    next_addr        = addr;
    next_words_left  = words_left;
    next_with_safety = with_safety;
    next_sck_seen    = sck_seen;
    next_snap_pulse  = 1'b0;
    next_clr_pend    = clr_pend;
    crc_restart      = 1'b0;
    crc_step         = 1'b0;
    crc_bit          = 1'b0;
    push             = 1'b0;
    acc_err          = 1'b0;
    clr_now          = 1'b0;
    tx_word          = 16'h0000;
    if (cs_high) begin
      // deselect ends or aborts anything in flight
      next_state    = ASSP_IDLE;
      next_bitcnt   = 4'h0;
      next_tx_on    = 1'b0;
      crc_restart   = 1'b1;
      next_sck_seen = 1'b0;
      if (cs_rise) begin
        next_snap_pulse = !sck_seen;
        clr_now         = clr_pend;
        next_clr_pend   = 1'b0;
      end
    end else begin
      if (sck_rise || sck_fall) begin
        next_sck_seen = 1'b1;
      end
      if (cs_fall) begin
        // every selection starts with a command word
        next_state  = ASSP_CMD;
        next_bitcnt = 4'h0;
        crc_restart = 1'b1;
      end else if (sck_rise && (state == ASSP_RDATA || state == ASSP_SAFE)) begin
        // device changes the line on the rising edge
        next_tx_on = 1'b1;
        if (bitcnt == 4'h0) begin
          if (state == ASSP_RDATA) begin
            if (assp_access_ok(key, addr)) begin
              tx_word = snap ? rd_snap_data : rd_live_data;
              if (addr == STATUS_ADDR) begin
                next_clr_pend = 1'b1;
              end
            end else begin
              acc_err = 1'b1;
            end
          end else begin
            tx_word = {rst_ok, sys_ok, acc_ok,
                       !(angle_invalid_flag || raw_component_invalid_flag),
                       sensor_number_response, 8'h00};
          end
          next_shift = tx_word;
          next_dout  = tx_word[15];
        end else if (state == ASSP_SAFE && bitcnt == CRC_SWAP_BIT) begin
          next_shift = {~crc, 8'h00};
          next_dout  = ~crc[7];
        end else begin
          next_dout = shift[15];
        end
      end else if (sck_fall && state != ASSP_IDLE && state != ASSP_DONE) begin
        // receiver samples on the falling edge, msb first
        crc_bit     = (state == ASSP_RDATA || state == ASSP_SAFE) ? shift[15] : din;
        crc_step    = !(state == ASSP_SAFE && bitcnt >= CRC_SWAP_BIT);
        next_shift  = word_in;
        next_bitcnt = bitcnt + 4'h1;
        if (bitcnt == LAST_BIT) begin
          // whole word done, act on it
          case (state)
            ASSP_CMD: begin
              next_key  = word_in[CMD_KEY_MSB:CMD_KEY_LSB];
              next_snap = word_in[CMD_SNAP_POS];
              next_addr = word_in[CMD_ADDR_MSB:CMD_ADDR_LSB];
              next_with_safety = (word_in[CMD_COUNT_MSB:CMD_COUNT_LSB] != 4'h0);
              next_words_left  = {1'b0, word_in[CMD_COUNT_MSB:CMD_COUNT_LSB]};
              if (word_in[CMD_RW_POS]) begin
                next_state = ASSP_RDATA;
                if (word_in[CMD_COUNT_MSB:CMD_COUNT_LSB] == 4'h0) begin
                  next_words_left = 5'h01;
                end
              end else if (word_in[CMD_COUNT_MSB:CMD_COUNT_LSB] == 4'h0) begin
                next_state = ASSP_SAFE;
              end else begin
                next_state = ASSP_WDATA;
              end
            end
            ASSP_RDATA, ASSP_WDATA: begin
              if (state == ASSP_WDATA) begin
                if (assp_access_ok(key, addr) && fifo_in_ready) begin
                  push = 1'b1;
                end else begin
                  acc_err = 1'b1;
                end
              end
              next_addr       = addr + 6'h01; // wraps from 3f to 00
              next_words_left = words_left - 5'h01;
              if (words_left == 5'h01) begin
                next_state = with_safety ? ASSP_SAFE : ASSP_DONE;
                next_tx_on = with_safety && (state == ASSP_RDATA);
              end
            end
            ASSP_SAFE: begin
              next_state = ASSP_DONE;
              next_tx_on = 1'b0;
            end
            default: next_state = ASSP_IDLE;
          endcase
        end
      end
    end
    // sticky status: a new error wins over the clear
    next_rst_ok = watchdog_overflow ? 1'b0 : (clr_now ? 1'b1 : rst_ok);
    next_sys_ok = sys_err ? 1'b0 : (clr_now ? 1'b1 : sys_ok);
    next_acc_ok = acc_err ? 1'b0 : (clr_now ? 1'b1 : acc_ok);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state       <= ASSP_IDLE;
      bitcnt      <= 4'h0;
      shift       <= 16'h0000;
      dout        <= 1'b1;
      tx_on       <= 1'b0;
      key         <= 4'h0;
      snap        <= 1'b0;
      addr        <= 6'h00;
      words_left  <= 5'h00;
      with_safety <= 1'b0;
      sck_seen    <= 1'b0;
      snap_pulse  <= 1'b0;
      clr_pend    <= 1'b0;
      rst_ok      <= 1'b0;
      sys_ok      <= 1'b1;
      acc_ok      <= 1'b1;
    end else if (ce) begin
      state       <= next_state;
      bitcnt      <= next_bitcnt;
      shift       <= next_shift;
      dout        <= next_dout;
      tx_on       <= next_tx_on;
      key         <= next_key;
      snap        <= next_snap;
      addr        <= next_addr;
      words_left  <= next_words_left;
      with_safety <= next_with_safety;
      sck_seen    <= next_sck_seen;
      snap_pulse  <= next_snap_pulse;
      clr_pend    <= next_clr_pend;
      rst_ok      <= next_rst_ok;
      sys_ok      <= next_sys_ok;
      acc_ok      <= next_acc_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checksum, write buffer and pin drive

  assp_crc8 u_crc (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .restart (crc_restart),
    .step    (crc_step),
    .bit_in  (crc_bit),
    .crc     (crc)
  );

  // full buffer refuses the word and raises the access error
  assp_fifo #(
    .WIDTH (22),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({addr, word_in}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  // open-drain only pulls low, push-pull drives both levels
  assign data_pin_out     = data_pin_open_drain_select ? 1'b0 : dout;
  assign data_pin_oe_n    = !(tx_on && (!data_pin_open_drain_select || !dout));
  assign rd_addr          = addr;
  assign snapshot_select  = snap;
  assign snapshot_capture = snap_pulse;

endmodule

/* sim/assp_props.sv */
// pin-level checks of the serial slave port
`timescale 1ns/1ps
module assp_props (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sck,
  input  wire logic        chip_select_n,
  input  wire logic        data_pin_out,
  input  wire logic        data_pin_oe_n,
  input  wire logic        data_pin_open_drain_select,
  input  wire logic        snapshot_select,
  input  wire logic        snapshot_capture,
  input  wire logic        wr_valid,
  input  wire logic        wr_ready,
  input  wire logic [5:0]  wr_addr,
  input  wire logic [15:0] wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////
  // open-drain mode may only pull the wire low
  od_low_a: assert property (
    data_pin_open_drain_select && $past(data_pin_open_drain_select) |-> !data_pin_out)
    else $error("open-drain output driven high");
  // a long deselect always leaves the wire released
  idle_release_a: assert property (chip_select_n [*8] |-> data_pin_oe_n)
    else $error("data pin driven while deselected");
  // driven bits move only shortly after a clock rise
  bit_stand_a: assert property (
    $changed(data_pin_out) && !data_pin_oe_n && !$past(data_pin_oe_n) |-> $past(sck, 3))
    else $error("driven bit changed away from a clock rise");
  // capture is one pulse, after select has gone high
  capture_pulse_a: assert property (
    snapshot_capture |-> chip_select_n && $past(chip_select_n, 3) ##1 !snapshot_capture)
    else $error("snapshot capture malformed");
  // snapshot choice is fixed while a word is sent
  snap_stable_a: assert property (
    !data_pin_oe_n && !$past(data_pin_oe_n) |-> $stable(snapshot_select))
    else $error("snapshot select moved during a read");
  // stalled write words keep still
  wr_hold_a: assert property (
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write word changed while stalled");
  // only addresses of an open window are written
  wr_range_a: assert property (wr_valid |-> wr_addr <= 6'h11)
    else $error("write outside the permitted range");
  // writes appear only inside a selected transfer
  push_frame_a: assert property ($rose(wr_valid) |-> !chip_select_n)
    else $error("write word outside a transfer");
endmodule
bind assp_port assp_props chk_u (
  .clk(clk), .rstn(rstn), .sck(sck), .chip_select_n(chip_select_n),
  .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
  .data_pin_open_drain_select(data_pin_open_drain_select),
  .snapshot_select(snapshot_select), .snapshot_capture(snapshot_capture),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
);

/* sim/assp_mst.sv */
// microcontroller model: drives select and clock, shares the data wire
`timescale 1ns/1ps
module assp_mst (
  output logic      sck,
  output logic      chip_select_n,
  output logic      data_pin_in,
  input  wire logic data_pin_out,
  input  wire logic data_pin_oe_n
);
  logic m_oe;
  logic m_bit;
  // wire level: device when enabled, else master, else the pull-up
  assign data_pin_in = !data_pin_oe_n ? data_pin_out : (m_oe ? m_bit : 1'b1);
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    m_oe = 1'b0;
    m_bit = 1'b1;
  end
  //////////////////////////////////////////////////////////////
  // n bits msb first; long high phase covers the device's sync delay
  task automatic word(input logic drv, input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'hffff;
    for (int i = 15; i > 15 - n; i--) begin
      sck = 1'b1;
      m_oe = drv;
      m_bit = w[i];
      #130;
      r[i] = data_pin_in;
      sck = 1'b0;
      #70;
    end
    m_oe = 1'b0;
  endtask
  // select with setup time
  task automatic sel();
    chip_select_n = 1'b0;
    #150;
  endtask
  // release and keep off well past the least deselect time
  task automatic desel();
    #150;
    chip_select_n = 1'b1;
    #800;
  endtask
endmodule

/* sim/tb.sv */
// self-checking bench of the angle sensor serial port
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        sck;
  logic        chip_select_n;
  logic        data_pin_in;
  logic        data_pin_out;
  logic        data_pin_oe_n;
  logic        data_pin_open_drain_select = 1'b0;
  logic [5:0]  rd_addr;
  logic        snapshot_select;
  logic        snapshot_capture;
  logic        wr_valid;
  logic        wr_ready = 1'b0;
  logic [5:0]  wr_addr;
  logic [15:0] wr_data;
  logic        supply_error_flag = 1'b0;
  logic        system_fault_flag = 1'b0;
  logic        watchdog_overflow = 1'b0;
  logic        angle_invalid_flag = 1'b0;
  logic        raw_component_invalid_flag = 1'b0;
  logic [7:0]  lv = 8'h00;
  logic [7:0]  sv = 8'h00;
  logic [15:0] wq[$];
  logic [15:0] got[$];
  logic [15:0] cq[$];
  logic [15:0] bad[3] = '{16'ha811, 16'h8051, 16'hd041};
  int          error_cnt = 0;
  int          checked = 0;
  int          caps = 0;
  wire  [15:0] rd_live_data = {lv, 2'b00, rd_addr};
  wire  [15:0] rd_snap_data = {sv, 2'b00, rd_addr};
  always #12.5 clk = ~clk;
  // user side: snapshot buffer and capture count
  always @(posedge clk) begin
    if (snapshot_capture) begin
      sv <= lv;
      caps <= caps + 1;
    end
  end
  assp_port dut_u (
    .clk(clk), .rstn(rstn), .ce(1'b1), .sck(sck), .chip_select_n(chip_select_n),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
    .data_pin_open_drain_select(data_pin_open_drain_select), .rd_addr(rd_addr),
    .snapshot_select(snapshot_select), .rd_live_data(rd_live_data),
    .rd_snap_data(rd_snap_data), .snapshot_capture(snapshot_capture),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .supply_error_flag(supply_error_flag), .system_fault_flag(system_fault_flag),
    .watchdog_overflow(watchdog_overflow), .angle_invalid_flag(angle_invalid_flag),
    .raw_component_invalid_flag(raw_component_invalid_flag)
  );
  assp_mst mst_u (
    .sck(sck), .chip_select_n(chip_select_n), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n)
  );
  //////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected safety word: crc over the first m words and the status byte, sent inverted
  function automatic logic [15:0] safe_w(input logic [3:0] st, input int m);
    logic [7:0]  c;
    logic [15:0] w;
    c = 8'hff;
    for (int k = 0; k <= m; k++) begin
      w = (k < m) ? cq[k] : {st, 4'he, 8'h00};
      for (int b = 15; b >= ((k < m) ? 0 : 8); b--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ w[b]) ? 8'h1d : 8'h00);
    end
    return {st, 4'he, ~c}; // sensor number zero answers on bit 8
  endfunction
  // one transfer: command, queued write words, turnaround, nr words back
  task automatic xfer(input logic [15:0] cmd, input int nr);
    logic [15:0] r;
    mst_u.sel();
    mst_u.word(1'b1, cmd, 16, r);
    cq = {cmd};
    foreach (wq[k]) begin
      mst_u.word(1'b1, wq[k], 16, r);
      cq.push_back(wq[k]);
    end
    #200;
    got = {};
    repeat (nr) begin
      mst_u.word(1'b0, 16'h0000, 16, r);
      got.push_back(r);
      cq.push_back(r);
    end
    mst_u.desel();
  endtask
  task automatic rd1(input logic [15:0] cmd, input logic [15:0] dw, input logic [3:0] st);
    xfer(cmd, 2);
    chk("data word", got[0], dw);
    chk("safety word", got[1], safe_w(st, 2));
  endtask
  //////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #1000000;
    error_cnt++;
    close_out();
  end
  initial begin
    logic [15:0] r;
    int          n;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk) lv <= 8'h3c;
    rd1(16'h8001, 16'h3c00, 4'h7);
    // open-drain burst of two words, reset indication now gone
    @(posedge clk) data_pin_open_drain_select <= 1'b1;
    xfer(16'h8032, 3);
    chk("addr 3", got[0], 16'h3c03);
    chk("addr 4", got[1], 16'h3c04);
    chk("safety", got[2], safe_w(4'hf, 3));
    // fast single read leaves the line to the pull-up
    @(posedge clk) data_pin_open_drain_select <= 1'b0;
    xfer(16'h8020, 2);
    chk("fast word", got[0], 16'h3c02);
    chk("released", got[1], 16'hffff);
    // select pulse without clock freezes the values
    @(posedge clk) lv <= 8'h11;
    mst_u.sel();
    mst_u.desel();
    @(posedge clk) lv <= 8'h22;
    chk("captures", 16'(caps), 16'h0001);
    rd1(16'h8411, 16'h1101, 4'hf);
    rd1(16'h8011, 16'h2201, 4'hf);
    // wrong key or address outside the key's window
    foreach (bad[k]) rd1(bad[k], 16'h0000, 4'hd);
    rd1(16'h8001, 16'h2200, 4'hd);
    rd1(16'h8011, 16'h2201, 4'hf);
    // select dropped after five bits, next transfer starts clean
    mst_u.sel();
    mst_u.word(1'b1, 16'hffff, 5, r);
    mst_u.desel();
    rd1(16'h8011, 16'h2201, 4'hf);
    // supply fault, bad raw components and a watchdog pulse
    @(posedge clk) {supply_error_flag, raw_component_invalid_flag, watchdog_overflow} <= 3'h7;
    @(posedge clk) watchdog_overflow <= 1'b0;
    rd1(16'h8011, 16'h2201, 4'h2);
    @(posedge clk) {supply_error_flag, raw_component_invalid_flag} <= 2'h0;
    @(posedge clk) {system_fault_flag, angle_invalid_flag} <= 2'h3;
    rd1(16'h8001, 16'h2200, 4'h2);
    @(posedge clk) {system_fault_flag, angle_invalid_flag} <= 2'h0;
    rd1(16'h8001, 16'h2200, 4'hb);
    // nine writes into an eight-word buffer, consumer stalled
    for (int k = 0; k < 9; k++) wq.push_back(16'h1000 + 16'(k));
    xfer(16'h5059, 1);
    chk("write safety", got[0], safe_w(4'hd, 10));
    wq = {};
    @(posedge clk) wr_ready <= 1'b1;
    n = 0;
    // look between edges, where the head word and the handshake are settled
    for (int t = 0; t < 40; t++) begin
      @(negedge clk);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
        chk("write addr", 16'(wr_addr), 16'h0005 + 16'(n));
        chk("write data", wr_data, 16'h1000 + 16'(n));
        n++;
      end
    end
    chk("writes kept", 16'(n), 16'h0008);
    close_out();
  end
endmodule
